// ---- include/startup_clk_pkg.sv ----
// Operation
// - with the feature on and a crystal primary mode, core runs from the internal clock chosen by internal_freq_select until primary ready.
// - two-speed start-up acts only while the switchover enable bit is set.
// - reset or Sleep wake selects internal clock; after power-on, once power-up timer expires.
// - start-up timer expiry switches the core to the primary clock and primary run mode when system_clock_select is 0; other selects run it on the internal clock.
// - exits from other power-managed modes ignore the switchover enable bit.
// - such exits keep the current clock source until the primary clock is ready.
// - Sleep entries are honoured before the start-up timer expires; clock select changes take effect only after it.
// - control register bit 3 reads 1 on primary clock, 0 on internal clock.
package startup_clk_pkg;

  // ==========================================================
  // control register layout
  localparam int        FLAG_BIT      = 3;
  localparam int        FREQ_LSB      = 4;
  localparam int        SEL_LSB       = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [2:0] FREQ_SLOW    = 3'h0;
  localparam logic [1:0] SEL_PRIMARY  = 2'h0;

  // ==========================================================
  // crystal primary modes
  localparam logic [2:0] CRYSTAL_LOW_POWER_MODE      = 3'h0;
  localparam logic [2:0] CRYSTAL_MEDIUM_MODE         = 3'h1;
  localparam logic [2:0] CRYSTAL_HIGH_SPEED_MODE     = 3'h2;
  localparam logic [2:0] CRYSTAL_HIGH_SPEED_PLL_MODE = 3'h3;

  // ==========================================================
  // start-up sequencer
  typedef enum logic [5:0] {
    ST_WAIT_PWRT   = 6'h01,
    ST_INT_RUN     = 6'h02,
    ST_PRIMARY_RUN = 6'h04,
    ST_SLEEP       = 6'h08,
    ST_WAIT_TIMER  = 6'h10,
    ST_PM_EXIT     = 6'h20
  } startup_state_t;

  typedef enum logic [2:0] {
    SRC_NONE     = 3'h1,
    SRC_INTERNAL = 3'h2,
    SRC_PRIMARY  = 3'h4
  } clk_src_t;

endpackage

// ---- src/two_speed_startup_clock_switch.sv ----
module two_speed_startup_clock_switch (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration and software controls
  input  wire logic        clock_switchover_enable,
  input  wire logic [2:0]  primary_osc_mode,
  input  wire logic [2:0]  internal_freq_select,
  input  wire logic [1:0]  system_clock_select,
  input  wire logic        sleep_enter,
  // device events, asynchronous
  input  wire logic        device_reset_req,
  input  wire logic        sleep_wake,
  input  wire logic        pm_mode_exit,
  input  wire logic        power_up_timer_done,
  input  wire logic        osc_startup_timer,
  // oscillator levels, asynchronous
  input  wire logic        internal_rc_slow_clock,
  input  wire logic        internal_fast_osc,
  input  wire logic        primary_osc,
  // status and clock out
  output logic             core_clk,
  output logic             primary_run_mode,
  output logic             primary_clock_active_flag,
  output logic [7:0]       osc_control_reg
);

  // ==========================================================
  // synchronisers
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [2:0] osc_prev;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1    <= 8'h00;
      sync2    <= 8'h00;
      osc_prev <= 3'h0;
    end
    else
    begin
      sync1    <= {device_reset_req, sleep_wake, pm_mode_exit, power_up_timer_done,
                   osc_startup_timer, internal_rc_slow_clock, internal_fast_osc, primary_osc};
      sync2    <= sync1;
      osc_prev <= sync2[2:0];
    end
  end

  logic reset_s, wake_s, pm_exit_s, pwrt_s, timer_s;
  logic [2:0] wake_prev;
  logic reset_ev, wake_ev, pm_exit_ev;
  assign reset_s   = sync2[7];
  assign wake_s    = sync2[6];
  assign pm_exit_s = sync2[5];
  assign pwrt_s    = sync2[4];
  assign timer_s   = sync2[3];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_prev <= 3'h0;
    else
      wake_prev <= {reset_s, wake_s, pm_exit_s};
  end
  assign reset_ev   = reset_s & ~wake_prev[2];
  assign wake_ev    = wake_s & ~wake_prev[1];
  assign pm_exit_ev = pm_exit_s & ~wake_prev[0];

  logic slow_tick, fast_tick, pri_tick;
  assign slow_tick = sync2[2] & ~osc_prev[2];
  assign fast_tick = sync2[1] & ~osc_prev[1];
  assign pri_tick  = sync2[0] & ~osc_prev[0];

  // ==========================================================
  // start-up sequencer
  startup_clk_pkg::startup_state_t state, next_state;
  logic two_speed;
  logic crystal_mode;
  assign crystal_mode = (primary_osc_mode == startup_clk_pkg::CRYSTAL_LOW_POWER_MODE)
                      | (primary_osc_mode == startup_clk_pkg::CRYSTAL_MEDIUM_MODE)
                      | (primary_osc_mode == startup_clk_pkg::CRYSTAL_HIGH_SPEED_MODE)
                      | (primary_osc_mode == startup_clk_pkg::CRYSTAL_HIGH_SPEED_PLL_MODE);
  // misconfigured non-crystal source still works: it simply waits for the timer
  assign two_speed = clock_switchover_enable & crystal_mode;

  always_comb
  begin
    next_state = state;
    case (state)
      startup_clk_pkg::ST_WAIT_PWRT:
        if (pwrt_s)
          next_state = two_speed ? startup_clk_pkg::ST_INT_RUN : startup_clk_pkg::ST_WAIT_TIMER;
      startup_clk_pkg::ST_INT_RUN:
        if (sleep_enter)
          next_state = startup_clk_pkg::ST_SLEEP;
        else if (timer_s)
          next_state = startup_clk_pkg::ST_PRIMARY_RUN;
      startup_clk_pkg::ST_PRIMARY_RUN:
        if (sleep_enter)
          next_state = startup_clk_pkg::ST_SLEEP;
        else if (pm_exit_ev)
          next_state = startup_clk_pkg::ST_PM_EXIT;
      startup_clk_pkg::ST_SLEEP:
        if (wake_ev)
          next_state = two_speed ? startup_clk_pkg::ST_INT_RUN : startup_clk_pkg::ST_WAIT_TIMER;
      startup_clk_pkg::ST_WAIT_TIMER:
        if (timer_s)
          next_state = startup_clk_pkg::ST_PRIMARY_RUN;
      startup_clk_pkg::ST_PM_EXIT:
        if (sleep_enter)
          next_state = startup_clk_pkg::ST_SLEEP;
        else if (timer_s)
          next_state = startup_clk_pkg::ST_PRIMARY_RUN;
      default:
        next_state = startup_clk_pkg::ST_WAIT_PWRT;
    endcase
    if (reset_ev)
      next_state = two_speed ? startup_clk_pkg::ST_INT_RUN : startup_clk_pkg::ST_WAIT_TIMER;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= startup_clk_pkg::ST_WAIT_PWRT;
    else
      state <= next_state;
  end

  // ==========================================================
  // wanted clock source
  startup_clk_pkg::clk_src_t want_src, active_src, pm_src;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pm_src <= startup_clk_pkg::SRC_NONE;
    else if (pm_exit_ev && state == startup_clk_pkg::ST_PRIMARY_RUN)
      pm_src <= active_src;
  end

  always_comb
  begin
    case (state)
      startup_clk_pkg::ST_INT_RUN:
        want_src = startup_clk_pkg::SRC_INTERNAL;
      startup_clk_pkg::ST_PRIMARY_RUN:
        want_src = (system_clock_select == startup_clk_pkg::SEL_PRIMARY) ? startup_clk_pkg::SRC_PRIMARY
                 : startup_clk_pkg::SRC_INTERNAL;
      startup_clk_pkg::ST_PM_EXIT:
        want_src = pm_src;
      default:
        want_src = startup_clk_pkg::SRC_NONE;
    endcase
  end

  // ==========================================================
  // glitch-free core clock: toggles on ticks of the active source,
  // source changes only while low, so the high phase is never cut short
  logic int_tick, sel_tick;
  assign int_tick = (internal_freq_select == startup_clk_pkg::FREQ_SLOW) ? slow_tick : fast_tick;
  always_comb
  begin
    case (active_src)
      startup_clk_pkg::SRC_INTERNAL: sel_tick = int_tick;
      startup_clk_pkg::SRC_PRIMARY:  sel_tick = pri_tick;
      default:                       sel_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_src <= startup_clk_pkg::SRC_NONE;
      core_clk   <= 1'b0;
    end
    else if (!core_clk && want_src != active_src)
      active_src <= want_src;
    else if (sel_tick)
      core_clk   <= ~core_clk;
  end

  // ==========================================================
  // status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      primary_run_mode          <= 1'b0;
      primary_clock_active_flag <= 1'b0;
      osc_control_reg           <= startup_clk_pkg::CTRL_RESET;
    end
    else
    begin
      primary_run_mode          <= (state == startup_clk_pkg::ST_PRIMARY_RUN)
                                 & (active_src == startup_clk_pkg::SRC_PRIMARY);
      primary_clock_active_flag <= (active_src == startup_clk_pkg::SRC_PRIMARY);
      osc_control_reg           <= CTRL_RESET_OR_FIELDS(internal_freq_select, system_clock_select,
                                                        active_src == startup_clk_pkg::SRC_PRIMARY);
    end
  end

  function automatic logic [7:0] CTRL_RESET_OR_FIELDS(input logic [2:0] f, input logic [1:0] s, input logic p);
    logic [7:0] r;
    r = startup_clk_pkg::CTRL_RESET;
    r[startup_clk_pkg::FREQ_LSB +: 3] = f;
    r[startup_clk_pkg::SEL_LSB +: 2]  = s;
    r[startup_clk_pkg::FLAG_BIT]      = p;
    return r;
  endfunction

  // ==========================================================
  // checks
  property p_int_until_timer;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_INT_RUN && !timer_s && !sleep_enter && !reset_ev)
      |=> (state == startup_clk_pkg::ST_INT_RUN);
  endproperty
  a_int_until_timer: assert property (p_int_until_timer) else $error("left internal run early");

  property p_enable_gate;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_SLEEP && wake_ev && !reset_ev && !two_speed)
      |=> (state == startup_clk_pkg::ST_WAIT_TIMER);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("two-speed used while disabled");

  property p_pwrt_first;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_WAIT_PWRT && pwrt_s && !reset_ev && two_speed)
      |=> (state == startup_clk_pkg::ST_INT_RUN) ##1 (want_src == startup_clk_pkg::SRC_INTERNAL);
  endproperty
  a_pwrt_first: assert property (p_pwrt_first) else $error("no internal clock after power-up");

  property p_timer_switch;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_INT_RUN && timer_s && !sleep_enter && !reset_ev)
      |=> (state == startup_clk_pkg::ST_PRIMARY_RUN);
  endproperty
  a_timer_switch: assert property (p_timer_switch) else $error("timer expiry did not switch");

  property p_pm_exit_hold;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_PRIMARY_RUN && pm_exit_ev && !sleep_enter && !reset_ev)
      |=> (state == startup_clk_pkg::ST_PM_EXIT) && (want_src == $past(active_src));
  endproperty
  a_pm_exit_hold: assert property (p_pm_exit_hold) else $error("power-managed exit changed source");

  property p_sleep_early;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_INT_RUN && sleep_enter && !reset_ev)
      |=> (state == startup_clk_pkg::ST_SLEEP);
  endproperty
  a_sleep_early: assert property (p_sleep_early) else $error("sleep refused during start-up");

  property p_flag;
    @(posedge clk) disable iff (rst)
    1'b1 |=> (osc_control_reg[startup_clk_pkg::FLAG_BIT] == $past(active_src == startup_clk_pkg::SRC_PRIMARY))
             && (primary_clock_active_flag == osc_control_reg[startup_clk_pkg::FLAG_BIT]);
  endproperty
  a_flag: assert property (p_flag) else $error("status bit does not track source");

  property p_glitch_free;
    @(posedge clk) disable iff (rst)
    (active_src != $past(active_src)) |-> !core_clk && !$past(core_clk);
  endproperty
  a_glitch_free: assert property (p_glitch_free) else $error("source changed while clock high");

  property p_pm_ignores_enable;
    @(posedge clk) disable iff (rst)
    (state == startup_clk_pkg::ST_PM_EXIT && !timer_s && !sleep_enter && !reset_ev)
      |=> (state == startup_clk_pkg::ST_PM_EXIT) && (want_src == $past(want_src));
  endproperty
  a_pm_ignores_enable: assert property (p_pm_ignores_enable) else $error("exit used two-speed");

endmodule

// ---- sim/osc_model.sv ----
module osc_model (
  // oscillator levels, free running and unrelated to clk
  output logic internal_rc_slow_clock,
  output logic internal_fast_osc,
  output logic primary_osc
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // oscillators, all slower than clk/2
  initial
  begin
    internal_rc_slow_clock = 1'b0;
    internal_fast_osc = 1'b0;
    primary_osc = 1'b0;
  end

  always #350 internal_rc_slow_clock = ~internal_rc_slow_clock;
  always #157 internal_fast_osc = ~internal_fast_osc;
  always #233 primary_osc = ~primary_osc;
endmodule

// ---- sim/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // stimulus and observation
  logic       clk, rst, en, slp, rreq, wake, pmx, pwrt, osc_ready;
  logic [2:0] mode, freq;
  logic [1:0] sel;
  logic       rc, fo, po, core_clk, prm, flag;
  logic [7:0] ctrl;
  int         bad_count, n_tests, hi_len;

  osc_model osc_model_inst (.internal_rc_slow_clock(rc), .internal_fast_osc(fo), .primary_osc(po));

  two_speed_startup_clock_switch two_speed_startup_clock_switch_inst (
    .clk(clk), .rst(rst), .clock_switchover_enable(en), .primary_osc_mode(mode),
    .internal_freq_select(freq), .system_clock_select(sel), .sleep_enter(slp),
    .device_reset_req(rreq), .sleep_wake(wake), .pm_mode_exit(pmx), .power_up_timer_done(pwrt),
    .osc_startup_timer(osc_ready), .internal_rc_slow_clock(rc), .internal_fast_osc(fo), .primary_osc(po),
    .core_clk(core_clk), .primary_run_mode(prm), .primary_clock_active_flag(flag), .osc_control_reg(ctrl));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(4);
    s = 1'b0;
    step(4);
  endtask

  task automatic toggles(int cycles, output int n);
    logic last;
    n = 0;
    last = core_clk;
    repeat (cycles)
    begin
      step(1);
      if (core_clk !== last)
        n++;
      last = core_clk;
    end
  endtask

  task automatic wait_prm(logic v);
    for (int i = 0; i < 200 && prm !== v; i++)
      step(1);
    cmp("primary_run_mode_wait", 8'(v), 8'(prm));
    if (prm !== v)
      conclude();
  endtask

  // high phase never cut short
  always @(posedge clk)
  begin
    if (core_clk === 1'b1)
      hi_len <= hi_len + 1;
    else
    begin
      if (hi_len != 0 && hi_len < 3)
        cmp("core_clk_high_cycles", 8'h03, 8'(hi_len));
      hi_len <= 0;
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_por;
    int n;
    toggles(30, n);
    cmp("toggles_before_pwrt", 8'h00, 8'(n));
    pwrt = 1'b1;
    step(10);
    toggles(100, n);
    cmp("slow_rc_toggles", 8'h01, 8'(n >= 4 && n <= 10));
    cmp("ctrl_internal", 8'h00, ctrl);
    osc_ready = 1'b1;
    wait_prm(1'b1);
    step(2);
    cmp("flag_primary", 8'h01, 8'(flag));
    cmp("ctrl_bit3_primary", 8'h08, ctrl);
    $display("test por done");
  endtask

  task automatic t_pm_exit;
    int n;
    osc_ready = 1'b0;
    step(4);
    pulse(pmx);
    toggles(100, n);
    cmp("pm_exit_toggles", 8'h01, 8'(n >= 6));
    cmp("pm_exit_flag", 8'h01, 8'(flag));
    osc_ready = 1'b1;
    wait_prm(1'b1);
    $display("test pm exit done");
  endtask

  task automatic t_sleep;
    int n;
    freq = 3'h5;
    sel = 2'h2;
    osc_ready = 1'b0;
    pulse(rreq);
    step(6);
    cmp("ctrl_fields", 8'h52, ctrl);
    toggles(60, n);
    cmp("reset_fast_toggles", 8'h01, 8'(n >= 8));
    pulse(slp);
    step(10);
    toggles(60, n);
    cmp("sleep_toggles", 8'h00, 8'(n));
    pulse(wake);
    step(6);
    toggles(100, n);
    cmp("wake_fast_toggles", 8'h01, 8'(n >= 12));
    cmp("wake_flag", 8'h00, 8'(flag));
    $display("test sleep done");
  endtask

  task automatic t_off;
    int n;
    sel = 2'h0;
    for (int k = 0; k < 2; k++)
    begin
      en = 1'(k);
      mode = k ? 3'h4 : 3'h2;
      osc_ready = 1'b0;
      pulse(rreq);
      step(10);
      toggles(60, n);
      cmp("off_toggles", 8'h00, 8'(n));
      osc_ready = 1'b1;
      wait_prm(1'b1);
      // sleep and wake with the feature off or a non-crystal primary mode: clock stays stopped until the timer
      osc_ready = 1'b0;
      pulse(slp);
      pulse(wake);
      step(4);
      toggles(40, n);
      cmp("off_wake_toggles", 8'h00, 8'(n));
      cmp("off_wake_flag", 8'h00, 8'(flag));
      osc_ready = 1'b1;
      wait_prm(1'b1);
    end
    $display("test disabled done");
  endtask

  initial
  begin
    rst = 1'b1;
    en = 1'b1;
    mode = 3'h2;
    freq = 3'h0;
    sel = 2'h0;
    slp = 1'b0;
    rreq = 1'b0;
    wake = 1'b0;
    pmx = 1'b0;
    pwrt = 1'b0;
    osc_ready = 1'b0;
    step(10);
    rst = 1'b0;
    t_por();
    t_pm_exit();
    t_sleep();
    t_off();
    conclude();
  end
endmodule
